// *** rtl/scs_clock_select.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01: Select 11 drives from direct clock pin
// R02: Direct drive keeps the input duty cycle
// R03: Select 10 with bypass uses prescaler
// R04: Prescaler divides by setting plus one
// R05: Factor one passes oscillator duty cycle
// R06: Largest prescaler factor is 1024
// R07: Software sets wait count per frequency
// R08: Waits only for non-sequential accesses; code also waits on sequential accesses that miss the prefetch
// R09: Select 00 runs from wakeup clock
// R10: Select 10 without bypass uses loop
// R11: Changes apply only at safe edges
module scs_clock_select import scs_pkg::*; (
  input wire logic sys_clk, // 25 MHz block clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] regAddr, // Register byte address
  input wire logic [DATA_W-1:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe
  input wire logic direct_clock_input_pin, // External direct clock
  input wire logic crystal_input_pin, // Crystal oscillator clock
  input wire logic intOscIn, // Internal clock source
  input wire logic wakeupClkIn, // Low-frequency wakeup clock
  input wire logic loopClkIn, // Multiplying loop output
  output logic loopEnable, // Enables the multiplying loop
  output logic sysClkOut, // Generated system clock level
  input wire logic memReq, // Memory access request
  input wire logic memSequential, // Access follows the previous one
  input wire logic prefetchHit, // Sequential access served by prefetch
  output logic memWaitValid, // Wait figure valid pulse
  output logic [WAIT_W-1:0] memWaitCycles // Wait states for this access
);
  logic [PIN_N-1:0] pinRaw;
  logic [PIN_N-1:0] pinMeta_q;
  logic [PIN_N-1:0] pinSync_q;

  logic [1:0] sys_clock_source_select_q;
  logic vco_bypass_bit_q;
  logic oscInternal_q;
  logic [DIV_W-1:0] output_divider_setting_q;
  logic [WAIT_W-1:0] nvm_wait_count_q;

  logic [1:0] actSel_q;
  logic actBypass_q;
  logic actOscInt_q;
  logic [DIV_W-1:0] actDiv_q;

  logic sysClk_q;
  logic sysClk_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic memWaitValid_q;
  logic [WAIT_W-1:0] memWait_q;
  logic [WAIT_W-1:0] memWait_d;

  logic changePending;
  logic commit;
  logic actOsc;
  logic pendOsc;
  logic presOut;
  logic pendPres;
  logic pendLevel;
  logic [DIV_W-1:0] divForPres;
  logic wrCtrl;
  logic wrWait;
  logic rdCtrl;
  logic rdWait;
  logic rdStatus;
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] statusWord;

  // Level seen on the system clock for a given configuration
  function automatic logic pickLevel(input logic [1:0] sel, input logic byp,
                                     input logic pres, input logic [PIN_N-1:0] pins);
    logic lvl;
    lvl = pins[PIN_WAKEUP];
    if (sel == SEL_DIRECT) begin
      lvl = pins[PIN_DIRECT];
    end else if (sel == SEL_PRESC) begin
      lvl = byp ? pres : pins[PIN_LOOP];
    end
    return lvl;
  endfunction

  // Clock pins are asynchronous to sys_clk: two stages each
  assign pinRaw = {loopClkIn, wakeupClkIn, intOscIn, crystal_input_pin, direct_clock_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          pinMeta_q[gi] <= 1'b0;
          pinSync_q[gi] <= 1'b0;
        end else begin
          pinMeta_q[gi] <= pinRaw[gi];
          pinSync_q[gi] <= pinMeta_q[gi];
        end
      end
    end
  endgenerate

  // Register decode
  assign wrCtrl = regWr && (regAddr == ADDR_CTRL);
  assign wrWait = regWr && (regAddr == ADDR_WAIT);
  assign rdCtrl = regRd && (regAddr == ADDR_CTRL);
  assign rdWait = regRd && (regAddr == ADDR_WAIT);
  assign rdStatus = regRd && (regAddr == ADDR_STATUS);

  assign ctrlWord = {18'h0, output_divider_setting_q, oscInternal_q, vco_bypass_bit_q,
                     sys_clock_source_select_q};
  assign statusWord = {14'h0, actDiv_q, 3'h0, actBypass_q, actSel_q, loopEnable,
                       changePending};
  assign rdata_d = rdCtrl ? ctrlWord :
                   rdWait ? {29'h0, nvm_wait_count_q} :
                   rdStatus ? statusWord : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sys_clock_source_select_q <= RST_SEL;
      vco_bypass_bit_q <= RST_BYPASS;
      oscInternal_q <= RST_OSCINT;
      output_divider_setting_q <= RST_DIV;
    end else if (wrCtrl) begin
      sys_clock_source_select_q <= regWdata[CTRL_SEL_LSB +: 2];
      vco_bypass_bit_q <= regWdata[CTRL_BYPASS_BIT];
      oscInternal_q <= regWdata[CTRL_OSCINT_BIT];
      output_divider_setting_q <= regWdata[CTRL_DIV_LSB +: DIV_W];
    end
  end

  // Software owns the choice of wait count per frequency band
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      nvm_wait_count_q <= RST_WAIT;
    end else if (wrWait) begin
      nvm_wait_count_q <= regWdata[WAIT_W-1:0]; // R07
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;

  // Written settings wait in the shadow until both clocks are low
  assign changePending = (sys_clock_source_select_q != actSel_q) ||
                         (vco_bypass_bit_q != actBypass_q) ||
                         (oscInternal_q != actOscInt_q) ||
                         (output_divider_setting_q != actDiv_q);
  assign pendOsc = oscInternal_q ? pinSync_q[PIN_INTOSC] : pinSync_q[PIN_XTAL];
  // A restarted divider starts low, so only factor one shows the oscillator at once
  assign pendPres = (output_divider_setting_q == '0) ? pendOsc : 1'b0;
  assign pendLevel = pickLevel(sys_clock_source_select_q, vco_bypass_bit_q, pendPres, pinSync_q);
  assign commit = changePending && !sysClk_q && !pendLevel; // R11

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      actSel_q <= RST_SEL;
      actBypass_q <= RST_BYPASS;
      actOscInt_q <= RST_OSCINT;
      actDiv_q <= RST_DIV;
    end else if (commit) begin
      actSel_q <= sys_clock_source_select_q; // R11
      actBypass_q <= vco_bypass_bit_q;
      actOscInt_q <= oscInternal_q;
      actDiv_q <= output_divider_setting_q;
    end
  end

  assign actOsc = actOscInt_q ? pinSync_q[PIN_INTOSC] : pinSync_q[PIN_XTAL]; // R03
  assign divForPres = commit ? output_divider_setting_q : actDiv_q;

  scs_prescaler u_prescaler (
    .sysClk(sys_clk),
    .resetn(resetn),
    .oscLevel(commit ? pendOsc : actOsc),
    .divSetting(divForPres),
    .restart(commit),
    .presOut(presOut)
  );

  // Reserved select 01 falls back to the wakeup clock rather than stopping
  assign sysClk_d = commit ? pendLevel :
                    pickLevel(actSel_q, actBypass_q, presOut, pinSync_q); // R01 R02 R03 R09 R10
  assign loopEnable = (actSel_q == SEL_PRESC) && !actBypass_q; // R10

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sysClk_q <= 1'b0;
    end else begin
      sysClk_q <= sysClk_d;
    end
  end

  assign sysClkOut = sysClk_q;

  // Prefetch hides the waits of sequential accesses it already holds
  assign memWait_d = (memSequential && prefetchHit) ? '0 : nvm_wait_count_q; // R08

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      memWaitValid_q <= 1'b0;
      memWait_q <= '0;
    end else begin
      memWaitValid_q <= memReq;
      memWait_q <= memReq ? memWait_d : '0;
    end
  end

  assign memWaitValid = memWaitValid_q;
  assign memWaitCycles = memWait_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_direct;
    (actSel_q == SEL_DIRECT && !commit) |=> (sysClkOut == $past(pinSync_q[PIN_DIRECT]));
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive not following pin"); // R01

  property p_direct_duty;
    // Every output edge matches one input edge, so phase lengths carry over
    (actSel_q == SEL_DIRECT && !commit) ##1 (actSel_q == SEL_DIRECT && !commit)
      |=> ((sysClkOut != $past(sysClkOut))
           == ($past(pinSync_q[PIN_DIRECT]) != $past(pinSync_q[PIN_DIRECT], 2)));
  endproperty
  a_direct_duty: assert property (p_direct_duty) else $error("direct drive changed duty"); // R02

  property p_presc;
    (actSel_q == SEL_PRESC && actBypass_q && !commit) |=> (sysClkOut == $past(presOut));
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler mode not using prescaler"); // R03

  property p_factor_one;
    (actSel_q == SEL_PRESC && actBypass_q && actDiv_q == '0 && !commit)[*2]
      |=> (sysClkOut == $past(actOsc, 2));
  endproperty
  a_factor_one: assert property (p_factor_one) else $error("factor one not pass-through"); // R05

  property p_wakeup;
    (actSel_q == SEL_WAKEUP && !commit) |=> (sysClkOut == $past(pinSync_q[PIN_WAKEUP]));
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wakeup mode not following wakeup clock"); // R09

  property p_loop;
    (actSel_q == SEL_PRESC && !actBypass_q && !commit)
      |=> (loopEnable && sysClkOut == $past(pinSync_q[PIN_LOOP]));
  endproperty
  a_loop: assert property (p_loop) else $error("loop mode not using loop output"); // R10

  property p_safe_switch;
    // A write in the commit cycle legally leaves a fresh change pending
    (commit && !wrCtrl) |-> (!sysClkOut ##1 (!sysClkOut && !changePending));
  endproperty
  a_safe_switch: assert property (p_safe_switch) else $error("switch not at a low phase"); // R11

  property p_waits;
    (memReq && !memSequential) |=> (memWaitValid && memWaitCycles == $past(nvm_wait_count_q));
  endproperty
  a_waits: assert property (p_waits) else $error("non-sequential access lost its waits"); // R08

  property p_prefetch;
    (memReq && memSequential && prefetchHit) |=> (memWaitCycles == '0);
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("prefetched access was stalled"); // R08

  c_to_direct: cover property (commit && sys_clock_source_select_q == SEL_DIRECT);
  c_to_loop: cover property (commit && sys_clock_source_select_q == SEL_PRESC && !vco_bypass_bit_q);
  c_to_presc: cover property (commit && vco_bypass_bit_q && output_divider_setting_q != '0);
endmodule
`default_nettype wire

// *** rtl/scs_pkg.sv ***
package scs_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WAIT = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Control word fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_BYPASS_BIT = 2;
  localparam int CTRL_OSCINT_BIT = 3;
  localparam int CTRL_DIV_LSB = 4;
  localparam int DIV_W = 10;
  localparam int WAIT_W = 3;

  // Status word fields
  localparam int STAT_PENDING_BIT = 0;
  localparam int STAT_LOOPEN_BIT = 1;
  localparam int STAT_SEL_LSB = 2;
  localparam int STAT_BYPASS_BIT = 4;
  localparam int STAT_DIV_LSB = 8;

  // Source select encodings
  localparam logic [1:0] SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_PRESC = 2'h2;
  localparam logic [1:0] SEL_DIRECT = 2'h3;

  // Reset values
  localparam logic [1:0] RST_SEL = SEL_WAKEUP;
  localparam logic RST_BYPASS = 1'b1;
  localparam logic RST_OSCINT = 1'b1;
  localparam logic [DIV_W-1:0] RST_DIV = 10'h000;
  localparam logic [WAIT_W-1:0] RST_WAIT = 3'h4;

  // Synchronised clock pin indices
  localparam int PIN_DIRECT = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_INTOSC = 2;
  localparam int PIN_WAKEUP = 3;
  localparam int PIN_LOOP = 4;
  localparam int PIN_N = 5;
endpackage

// *** rtl/scs_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module scs_prescaler import scs_pkg::*; (
  input wire logic sysClk, // Block clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic oscLevel, // Synchronised oscillator level
  input wire logic [DIV_W-1:0] divSetting, // Factor minus one
  input wire logic restart, // Start a fresh output period
  output logic presOut // Divided clock level
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic oscPrev_q;
  logic out_q;
  logic out_d;
  logic oscRise;
  logic atEnd;
  logic [DIV_W:0] halfCnt;

  assign oscRise = oscLevel & ~oscPrev_q;
  assign atEnd = (cnt_q == divSetting);
  // High for ceil(K/2) oscillator periods, K = setting + 1
  assign halfCnt = ({1'b0, divSetting} + 11'h002) >> 1;
  assign cnt_d = restart ? divSetting :
                 (oscRise ? (atEnd ? '0 : cnt_q + 10'h001) : cnt_q); // R04 R06
  // Factor one passes the oscillator level straight through
  assign out_d = restart ? 1'b0 :
                 (divSetting == '0) ? oscLevel : // R05
                 (oscRise ? ({1'b0, cnt_d} < halfCnt) : out_q); // R04

  always_ff @(posedge sysClk) begin
    if (!resetn) begin
      cnt_q <= '0;
      oscPrev_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      oscPrev_q <= oscLevel;
      out_q <= out_d;
    end
  end

  assign presOut = out_q;

  default clocking cb @(posedge sysClk); endclocking
  default disable iff (!resetn);

  property p_wrap;
    (oscRise && atEnd && !restart) |=> (cnt_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("prescaler did not wrap at factor end"); // R04

  property p_range;
    (!restart && cnt_q <= divSetting && $stable(divSetting)) |=> (cnt_q <= $past(divSetting));
  endproperty
  a_range: assert property (p_range) else $error("prescaler count beyond factor"); // R06

  property p_period_start;
    (oscRise && atEnd && !restart && divSetting != '0) |=> presOut;
  endproperty
  a_period_start: assert property (p_period_start) else $error("period did not start high"); // R04

  c_max_factor: cover property (divSetting == 10'h3FF && oscRise && atEnd);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import scs_pkg::*;;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [PIN_N-1:0] pins = '0;
  logic loopEnable;
  logic sysClkOut;
  logic memReq = 1'b0;
  logic memSequential = 1'b0;
  logic prefetchHit = 1'b0;
  logic memWaitValid;
  logic [WAIT_W-1:0] memWaitCycles;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  integer seed = 32'h3A67B62C;
  // Distinct period per source, so a wrong mux shows in the counts
  int srcPer[PIN_N] = '{8, 6, 4, 10, 12};
  int srcHi[PIN_N] = '{3, 3, 2, 4, 6};

  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < PIN_N; i++) begin
      pins[i] <= (cyc % srcPer[i]) < srcHi[i];
    end
  end

  scs_clock_select scs_clock_select_i (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .direct_clock_input_pin(pins[PIN_DIRECT]), .crystal_input_pin(pins[PIN_XTAL]),
    .intOscIn(pins[PIN_INTOSC]), .wakeupClkIn(pins[PIN_WAKEUP]), .loopClkIn(pins[PIN_LOOP]),
    .loopEnable(loopEnable), .sysClkOut(sysClkOut), .memReq(memReq),
    .memSequential(memSequential), .prefetchHit(prefetchHit),
    .memWaitValid(memWaitValid), .memWaitCycles(memWaitCycles)
  );

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkCount(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdata;
  endtask

  // Two whole output periods from a rising edge: phase-independent counts
  task automatic measure(input int per, input int hi);
    int highs;
    int rises;
    logic prev;
    prev = 1'b1;
    for (int n = 0; n < 20000; n++) begin
      @(negedge sys_clk);
      if (prev === 1'b0 && sysClkOut === 1'b1) break;
      prev = sysClkOut;
    end
    highs = 0;
    rises = 0;
    for (int n = 0; n < 2 * per; n++) begin
      if (sysClkOut === 1'b1) highs++;
      if (prev === 1'b0 && sysClkOut === 1'b1) rises++;
      prev = sysClkOut;
      @(negedge sys_clk);
    end
    chkCount("high samples", 2 * hi, highs);
    chkCount("rising edges", 2, rises);
  endtask

  // Pin whose waveform the system clock must reproduce
  function automatic int srcOf(input logic [1:0] sel, input logic byp, input logic osc);
    int s;
    s = PIN_WAKEUP;
    if (sel == SEL_DIRECT) begin
      s = PIN_DIRECT;
    end else if (sel == SEL_PRESC) begin
      s = !byp ? PIN_LOOP : osc ? PIN_INTOSC : PIN_XTAL;
    end
    return s;
  endfunction

  // Division factor: setting plus one, only in prescaler mode
  function automatic int factorOf(input logic [1:0] sel, input logic byp,
                                  input logic [DIV_W-1:0] dv);
    return (sel == SEL_PRESC && byp) ? int'(dv) + 1 : 1;
  endfunction

  task automatic runMode(input logic [1:0] sel, input logic byp, input logic osc,
                         input logic [DIV_W-1:0] dv);
    logic [31:0] st;
    logic loopOn;
    int s;
    int k;
    wr(ADDR_CTRL, {18'h0, dv, osc, byp, sel});
    st = 32'h1;
    for (int n = 0; n < 3000 && st[STAT_PENDING_BIT] !== 1'b0; n++) rd(ADDR_STATUS, st);
    loopOn = (sel == SEL_PRESC) && !byp;
    s = srcOf(sel, byp, osc);
    k = factorOf(sel, byp, dv);
    chkWord("status", {14'h0, dv, 3'h0, byp, sel, loopOn, 1'b0}, st);
    chkWord("loopEnable", {31'h0, loopOn}, {31'h0, loopEnable});
    measure(k * srcPer[s], (k == 1) ? srcHi[s] : ((k + 1) / 2) * srcPer[s]);
  endtask

  task automatic memRun(input logic [WAIT_W-1:0] w);
    logic [DATA_W-1:0] v;
    logic pr;
    logic ps;
    logic ph;
    wr(ADDR_WAIT, {29'h0, w});
    rd(ADDR_WAIT, v);
    chkWord("wait word", {29'h0, w}, v);
    for (int i = 0; i < 30; i++) begin
      @(posedge sys_clk);
      pr = memReq;
      ps = memSequential;
      ph = prefetchHit;
      memReq <= 1'($random(seed));
      memSequential <= 1'($random(seed));
      prefetchHit <= 1'($random(seed));
      @(negedge sys_clk);
      chkWord("memWaitValid", {31'h0, pr}, {31'h0, memWaitValid});
      if (pr && ps && ph) begin
        chkCount("prefetch wait below full", 1, int'(memWaitCycles < w));
      end else begin
        chkWord("memWaitCycles", {29'h0, pr ? w : 3'h0}, {29'h0, memWaitCycles});
      end
    end
    @(posedge sys_clk);
    memReq <= 1'b0;
  endtask

  initial begin
    #(40 * 90000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    logic [DATA_W-1:0] v;
    // Look at the output between edges, where it has settled
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chkWord("sysClkOut in reset", 32'h0, {31'h0, sysClkOut});
    @(posedge sys_clk);
    resetn <= 1'b1;
    rd(ADDR_CTRL, v);
    chkWord("ctrl reset", {18'h0, RST_DIV, RST_OSCINT, RST_BYPASS, RST_SEL}, v);
    rd(ADDR_STATUS, v);
    chkWord("status reset", {14'h0, RST_DIV, 3'h0, RST_BYPASS, RST_SEL, 2'h0}, v);
    rd(ADDR_WAIT, v);
    chkWord("wait reset", {29'h0, RST_WAIT}, v);
    // Unmapped place: write ignored, read gives zero
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, v);
    chkWord("unmapped read", 32'h0, v);
    rd(ADDR_CTRL, v);
    chkWord("ctrl after unmapped write", {18'h0, RST_DIV, RST_OSCINT, RST_BYPASS, RST_SEL}, v);
    memRun(RST_WAIT);
    memRun(3'(($random(seed) & 3) + 1));
    runMode(SEL_WAKEUP, 1'b1, 1'b1, 10'h000);
    runMode(SEL_DIRECT, 1'b1, 1'b1, 10'h005);
    runMode(SEL_RESERVED, 1'b0, 1'b0, 10'h000);
    runMode(SEL_PRESC, 1'b0, 1'b1, 10'h000);
    runMode(SEL_PRESC, 1'b1, 1'b1, 10'h000);
    runMode(SEL_PRESC, 1'b1, 1'b0, 10'h000);
    runMode(SEL_PRESC, 1'b1, 1'b1, 10'h001);
    runMode(SEL_PRESC, 1'b1, 1'b0, 10'h002);
    runMode(SEL_PRESC, 1'b1, 1'b1, 10'h3FF);
    runMode(SEL_DIRECT, 1'b0, 1'b0, 10'h000);
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      runMode(v[1:0], v[2], v[3], {7'h0, v[6:4]});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
